// *** rtl/gpio_page_pkg.sv ***
/*
  Constants for the general pin block: register offsets, reset values, widths.
  Assumes a simple byte-wide register port with 10-bit addresses.
*/
// Function
// - Direction clear and function zero: pin is input, sampled level shown in input value.
// - Direction set and function zero: pin drives the output value bit.
// - Setting hold bit freezes the input value bit at its last sampled level while set.
// - Hold bit clear: input value bit follows the pin level while direction is clear and function is zero.
// - Page select is an unsigned 8-bit number naming the serial-bus page.
// - Function select zero is the only mode where direction and value bits govern.
`default_nettype none
package gpio_page_pkg;
  localparam int ADDR_W = 10;
  localparam int DATA_W = 8;
  localparam int PIN_N = 7;
  localparam int FUNC_W = 8;
  localparam logic [ADDR_W-1:0] FUNC_PIN0_OFS = 10'h260;
  localparam logic [ADDR_W-1:0] PIN_INPUT_VALUE_OFS = 10'h276;
  localparam logic [ADDR_W-1:0] PIN_OUTPUT_VALUE_OFS = 10'h278;
  localparam logic [ADDR_W-1:0] PIN_DIRECTION_CONTROL_OFS = 10'h27a;
  localparam logic [ADDR_W-1:0] PIN_INPUT_HOLD_OFS = 10'h27c;
  localparam logic [ADDR_W-1:0] REGISTER_PAGE_SELECT_OFS = 10'h27f;
  localparam logic [DATA_W-1:0] REG_RESET = 8'h00;
  localparam logic [FUNC_W-1:0] FUNC_CONTROL_ZERO = 8'h00;
endpackage : gpio_page_pkg
`default_nettype wire

// *** rtl/gpio_direction_latch_page.sv ***
/*
  Seven general pins with direction, output value, input hold and page select.
  Assumes a synchronous byte register port on the same clock; pins are async.
*/
`default_nettype none
module gpio_direction_latch_page (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // Register port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [gpio_page_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [gpio_page_pkg::DATA_W-1:0] reg_wdata,
  output logic [gpio_page_pkg::DATA_W-1:0] reg_rdata,
  // Per-pin function selects from the routing table
  input wire logic [gpio_page_pkg::PIN_N*gpio_page_pkg::FUNC_W-1:0] pin_function_select,
  // Pins
  input wire logic [gpio_page_pkg::PIN_N-1:0] pin_in,
  output logic [gpio_page_pkg::PIN_N-1:0] pin_out,
  output logic [gpio_page_pkg::PIN_N-1:0] pin_oe,
  // Page for serial-bus access
  output logic [gpio_page_pkg::DATA_W-1:0] page_select
);
  import gpio_page_pkg::*;

  logic [PIN_N-1:0] sync1_reg;
  logic [PIN_N-1:0] sync2_reg;
  logic [PIN_N-1:0] in_value_reg;
  logic [PIN_N-1:0] in_value_next;
  logic [PIN_N-1:0] out_value_reg;
  logic [PIN_N-1:0] direction_reg;
  logic [PIN_N-1:0] hold_reg;
  logic [DATA_W-1:0] page_reg;
  logic [PIN_N-1:0] func_zero;
  logic [PIN_N-1:0] drive_next;
  logic [DATA_W-1:0] rdata_next;

  wire wr_out = reg_wr && (reg_addr == PIN_OUTPUT_VALUE_OFS);
  wire wr_dir = reg_wr && (reg_addr == PIN_DIRECTION_CONTROL_OFS);
  wire wr_hold = reg_wr && (reg_addr == PIN_INPUT_HOLD_OFS);
  wire wr_page = reg_wr && (reg_addr == REGISTER_PAGE_SELECT_OFS);

  genvar g;
  generate
    for (g = 0; g < PIN_N; g++) begin : g_pin
      assign func_zero[g] =
        (pin_function_select[g*FUNC_W +: FUNC_W] == FUNC_CONTROL_ZERO);
      assign drive_next[g] = func_zero[g] && direction_reg[g];
      // Held bit keeps its value; otherwise follows the pin while it is an input
      assign in_value_next[g] = hold_reg[g] ? in_value_reg[g] :
        ((func_zero[g] && !direction_reg[g]) ? sync2_reg[g] : in_value_reg[g]);
    end
  endgenerate

  // Bit 7 of the four pin registers is never stored, so it reads back as zero; page select keeps all 8 bits
  assign rdata_next =
    (reg_addr == PIN_INPUT_VALUE_OFS) ? {1'b0, in_value_reg} :
    (reg_addr == PIN_OUTPUT_VALUE_OFS) ? {1'b0, out_value_reg} :
    (reg_addr == PIN_DIRECTION_CONTROL_OFS) ? {1'b0, direction_reg} :
    (reg_addr == PIN_INPUT_HOLD_OFS) ? {1'b0, hold_reg} :
    (reg_addr == REGISTER_PAGE_SELECT_OFS) ? page_reg : REG_RESET;

  // Pins are asynchronous: two flops before use
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else begin
      sync1_reg <= pin_in;
      sync2_reg <= sync1_reg;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      out_value_reg <= '0;
      direction_reg <= '0;
      hold_reg <= '0;
      page_reg <= REG_RESET;
    end else begin
      if (wr_out) out_value_reg <= reg_wdata[PIN_N-1:0];
      if (wr_dir) direction_reg <= reg_wdata[PIN_N-1:0];
      if (wr_hold) hold_reg <= reg_wdata[PIN_N-1:0];
      if (wr_page) page_reg <= reg_wdata;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      in_value_reg <= '0;
      pin_out <= '0;
      pin_oe <= '0;
      reg_rdata <= REG_RESET;
    end else begin
      in_value_reg <= in_value_next;
      pin_oe <= drive_next;
      pin_out <= out_value_reg & drive_next;
      if (reg_rd) reg_rdata <= rdata_next;
    end
  end

  assign page_select = page_reg;

endmodule : gpio_direction_latch_page
`default_nettype wire

// *** sim/gpio_page_checker.sv ***
/* Pin block port checks; assumes function selects stay steady. */
`default_nettype none
module gpio_page_checker (
  input wire logic clock, rst_b, reg_wr, reg_rd, input wire logic [9:0] reg_addr,
  input wire logic [7:0] reg_wdata, page_select, input wire logic [6:0] pin_oe,
  input wire logic [6:0] pin_out, input wire logic [55:0] pin_function_select,
  input wire logic [7:0] reg_rdata);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  wire pg = reg_wr && reg_addr == 10'h27f;
  wire dw = reg_wr && reg_addr == 10'h27a;
  a_page_load: assert property (pg |=> page_select == $past(reg_wdata)) else $error("page");
  a_page_keep: assert property (!pg |=> $stable(page_select)) else $error("page moved");
  a_dir_oe: assert property (dw |=> ##1 pin_oe[5:0] == $past(reg_wdata[5:0], 2))
    else $error("enable");
  a_out_gated: assert property ((pin_out & ~pin_oe) == 0) else $error("undriven");
  a_func_off: assert property ((pin_function_select[55:48] != 0) [*2] |-> !pin_oe[6])
    else $error("pin six");
  // Read data is registered and must stand until the next read strobe
  a_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata)) else $error("rdata");
  c_page: cover property (pg);
  c_dir: cover property (dw);
  c_read: cover property (reg_rd && reg_addr == 10'h276);
endmodule : gpio_page_checker
bind gpio_direction_latch_page gpio_page_checker u_chk (.*);
`default_nettype wire

// *** sim/board_pins.sv ***
/* Board side of the pins; undriven pins take the bench level. */
`default_nettype none
module board_pins (input wire logic [6:0] pin_out, pin_oe, ext_level, output logic [6:0] pin_in);
  timeunit 1ns; timeprecision 1ns;
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule : board_pins
`default_nettype wire

// *** sim/gpio_direction_latch_page_test.sv ***
/* Register sequences for the pin block; needs the bound checker and board model. */
`default_nettype none
module gpio_direction_latch_page_test;
  timeunit 1ns; timeprecision 1ns;
  logic clock = 0, rst_b = 0, reg_wr = 0, reg_rd = 0;
  logic [9:0] reg_addr = 10'h000;
  logic [7:0] reg_wdata = 8'h00, reg_rdata, page_select;
  logic [55:0] pin_function_select = {8'h01, 48'h0};
  logic [6:0] pin_in, pin_out, pin_oe, ext_level = 7'h00;
  int err_count = 0, total_checks = 0;
  gpio_direction_latch_page u_dut (.*);
  board_pins u_board (.*);
  initial forever #2 clock = ~clock;
  task automatic acc(input logic w, input logic [9:0] a, input logic [7:0] d);
    @(negedge clock) {reg_wr, reg_rd, reg_addr, reg_wdata} = {w, !w, a, d};
    @(negedge clock) {reg_wr, reg_rd} = 2'h0;
    @(negedge clock) total_checks += !w;
    err_count += (!w && reg_rdata !== d);
    if (!w && reg_rdata !== d) $display("unexpected %0t %h %h", $time, reg_rdata, d);
  endtask : acc
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected %0t %h %h", $time, got, exp);
    end
  endtask : chk
  task automatic report_and_stop;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : report_and_stop
  initial begin
    repeat (4) @(negedge clock);
    rst_b = 1;
    acc(0, 10'h27a, 8'h00); acc(0, 10'h27c, 8'h00); acc(0, 10'h000, 8'h00);
    acc(1, 10'h27f, 8'ha5); acc(0, 10'h27f, 8'ha5);
    acc(1, 10'h278, 8'hff); acc(1, 10'h27a, 8'hff); acc(0, 10'h27a, 8'h7f);
    chk({1'b0, pin_oe}, 8'h3f);
    chk({1'b0, pin_out}, 8'h3f);
    chk(page_select, 8'ha5);
    acc(1, 10'h27a, 8'h00); ext_level = 7'h55; repeat (4) @(negedge clock);
    chk({1'b0, pin_oe}, 8'h00);
    chk({1'b0, pin_out}, 8'h00);
    acc(0, 10'h276, 8'h15); acc(1, 10'h27c, 8'h01); ext_level = 7'h2a;
    repeat (4) @(negedge clock); acc(0, 10'h276, 8'h2b); report_and_stop();
  end
endmodule : gpio_direction_latch_page_test
`default_nettype wire
